//--- core/bank_window_decode.sv
// address to bank decoder for the four external windows
// assumes the type and size straps are stable while requests are decoded
`timescale 1ns/1ps
`default_nettype none
module bank_window_decode
  import ext_port_pkg::*;
(
  // request address and kind
  input  wire logic [31:0]          addr,
  input  wire access_kind_t         kind,
  // per-bank setup
  input  wire logic [3:0]           bank_is_sdram,
  input  wire logic [11:0]          sdram_size,
  // result
  output logic [3:0]                hit,
  output logic                      hit_sdram,
  output logic                      fetch_ok
);

  // ---------------------------------------------------------------
  // per-bank window compare
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    logic [31:0] base;
    logic [31:0] top;
    logic [31:0] sd_bytes;
    // bank zero starts above the internal space, others on the stride
    assign base = (b == 0) ? BANK0_BASE : BANK_STRIDE * 32'(b);
    // sdram window limited by configured size; 16-bit words so bytes/2
    assign sd_bytes = SDRAM_MIN_BYTES << ((sdram_size[3*b +: 3] > SDRAM_SIZE_MAX)
                      ? SDRAM_SIZE_MAX : sdram_size[3*b +: 3]); // R06
    assign top = bank_is_sdram[b]
                 ? (BANK_STRIDE * 32'(b)) + ((sd_bytes >> 1) > SDRAM_SPAN
                    ? SDRAM_SPAN : (sd_bytes >> 1))                 // R05 R23
                 : (BANK_STRIDE * 32'(b)) + ASYNC_SPAN;             // R03 R04 R23
    // partly used windows are left with holes, no remap
    assign hit[b] = (addr >= base) && (addr < top);                 // R22
  end

  // ---------------------------------------------------------------
  // type of the hit bank and fetch window check
  // ---------------------------------------------------------------
  always_comb
  begin
    hit_sdram = |(hit & bank_is_sdram);
    fetch_ok  = 1'b1;
    if (kind == KIND_FETCH_FIXED)
      fetch_ok = hit[0] && addr >= FIXED_FETCH_LO && addr <= FIXED_FETCH_HI; // R10 R11
    else if (kind == KIND_FETCH_COMP)
      // compressed code only runs from sdram
      fetch_ok = hit[0] && bank_is_sdram[0]
                 && addr >= COMP_FETCH_LO && addr <= COMP_FETCH_HI;       // R11 R12
  end

endmodule
`default_nettype wire

//--- core/ext_port_pkg.sv
// constants, types and timing counts for the external memory port decoder
// assumes a single 10 MHz peripheral-side clock and no software-visible registers
//
// Overview of operation
// [R01] four active-low bank selects let four devices of any type coexist
// [R02] each asynchronous bank holds its own independent wait-state timing
// [R03] async bank zero spans 6M words, banks one to three 8M each, no remap
// [R04] async windows: 0x200000-0x7FFFFF, 0x4000000, 0x8000000, 0xC000000 plus 8M
// [R05] sdram windows: bank n spans 0x4000000*n to +0x3FFFFFF, bank zero from 0x200000
// [R06] sdram banks each own a select and size 4M to 256M bytes
// [R07] sdram timing is programmable for slower memory devices
// [R08] attached memories must not be 32-bit wide parts
// [R09] dual-element normal-word sdram access carries both elements on 64-bit path
// [R10] instruction fetch from external memory only allowed in bank zero
// [R11] fixed fetch 0x200000-0x5FFFFF, compressed fetch 0x600000-0xFFFFFF
// [R12] compressed fetch: one 48-bit word may deliver three instructions
// [R13] acknowledge low inserts wait states; access completes after it returns high
// [R14] selects go low for addressed bank, timed with the address outputs
// [R15] selects idle without access; conditional access only when condition true
// [R16] read strobe asserted while reading external memory
// [R17] write strobe asserted while writing external memory
// [R18] after reset address pins in memory mode, low flags in flag mode
// [R19] address high-z in reset, driven low in boot; selects, strobes high-z
// [R20] selects two and three share flag pins, flag inputs after reset
// [R21] sixteen data pins can carry memory data or eight flag lines
// [R22] unmapped address asserts no select and no strobe
// [R23] each bank is sdram or async, choosing its window and controller
package ext_port_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_BANKS   = 4;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned PIN_ADDR_W  = 24;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned WIDE_W      = 64;
  localparam int unsigned FLAG_W      = 8;
  localparam int unsigned WAIT_W      = 4;

  // ---------------------------------------------------------------
  // address windows
  // ---------------------------------------------------------------
  localparam logic [31:0] BANK_STRIDE     = 32'h0400_0000;
  localparam logic [31:0] BANK0_BASE      = 32'h0020_0000;
  localparam logic [31:0] ASYNC_SPAN      = 32'h0080_0000;
  localparam logic [31:0] SDRAM_SPAN      = 32'h0400_0000;
  localparam logic [31:0] FIXED_FETCH_LO  = 32'h0020_0000;
  localparam logic [31:0] FIXED_FETCH_HI  = 32'h005F_FFFF;
  localparam logic [31:0] COMP_FETCH_LO   = 32'h0060_0000;
  localparam logic [31:0] COMP_FETCH_HI   = 32'h00FF_FFFF;

  // ---------------------------------------------------------------
  // sdram bank size codes: 4M bytes shifted left by code, up to 256M
  // ---------------------------------------------------------------
  localparam logic [2:0]  SDRAM_SIZE_MAX  = 3'h6;
  localparam logic [31:0] SDRAM_MIN_BYTES = 32'h0040_0000;

  // ---------------------------------------------------------------
  // reset values and sdram timing
  // ---------------------------------------------------------------
  localparam logic [3:0]  WAIT_RESET      = 4'h1;
  localparam logic [3:0]  SD_LAT_RESET    = 4'h2;
  localparam int unsigned BOOT_NS         = 400;
  localparam int unsigned CLK_NS          = 100;
  localparam int unsigned BOOT_CYCLES     = BOOT_NS / CLK_NS;

  typedef enum logic [1:0] {
    KIND_READ,
    KIND_WRITE,
    KIND_FETCH_FIXED,
    KIND_FETCH_COMP
  } access_kind_t;

  typedef enum {
    ST_BOOT,
    ST_IDLE,
    ST_ACCESS,
    ST_WAIT_ACK,
    ST_DONE
  } port_state_t;

endpackage

//--- core/external_port_bank_decoder.sv
// external memory port: bank select, async strobes, wait states, pin muxing
// assumes one 10 MHz clock; sdram command timing lives outside this block
`timescale 1ns/1ps
`default_nettype none
module external_port_bank_decoder
  import ext_port_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // request port from core and dma
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [31:0]          req_addr,
  input  wire access_kind_t         req_kind,
  input  wire logic                 req_cond_true,
  input  wire logic                 req_dual,
  input  wire logic [63:0]          req_wdata,
  output logic                      resp_valid,
  output logic                      resp_error,
  output logic [63:0]               resp_rdata,
  // bank setup straps
  input  wire logic [3:0]           bank_is_sdram,
  input  wire logic [11:0]          sdram_size,
  input  wire logic [15:0]          async_wait,
  input  wire logic [3:0]           sdram_latency,
  input  wire logic [1:0]           sel23_enable,
  input  wire logic                 data_flag_mode,
  // boot phase
  input  wire logic                 boot_active,
  // address pins
  output logic [23:0]               addr_out,
  output logic                      addr_oe,
  // data pins
  input  wire logic [15:0]          data_in,
  output logic [15:0]               data_out,
  output logic [15:0]               data_oe,
  // general flags on data pins
  input  wire logic [7:0]           gp_flag_out,
  input  wire logic [7:0]           gp_flag_oe,
  output logic [7:0]                gp_flag_in,
  // selects and strobes
  output logic [1:0]                bank_select_n,
  output logic                      bank_select_oe,
  output logic                      shared_flag_pin_2,
  output logic                      shared_flag_pin_2_oe,
  output logic                      shared_flag_pin_3,
  output logic                      shared_flag_pin_3_oe,
  output logic                      async_read_strobe,
  output logic                      async_write_strobe,
  output logic                      strobe_oe,
  output logic                      sdram_cycle,
  input  wire logic                 async_wait_ack_n
);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic       rst_meta;
  logic       rst_n;
  logic       ack_meta;
  logic       ack_ok;
  logic [15:0] din_meta;
  logic [15:0] din_sync;

  // reset leaves through two flops so release is clean
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ack and data arrive from the board, two flops each
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_meta <= 1'b1;
      ack_ok   <= 1'b1;
      din_meta <= 16'h0000;
      din_sync <= 16'h0000;
    end
    else
    begin
      ack_meta <= async_wait_ack_n;
      ack_ok   <= ack_meta;
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [3:0] hit;
  logic       hit_sdram;
  logic       fetch_ok;

  bank_window_decode u_decode (
    .addr          (req_addr),
    .kind          (req_kind),
    .bank_is_sdram (bank_is_sdram),
    .sdram_size    (sdram_size),
    .hit           (hit),
    .hit_sdram     (hit_sdram),
    .fetch_ok      (fetch_ok)
  );

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  port_state_t state;
  logic [3:0]  cur_sel;
  logic        cur_sdram;
  logic        cur_write;
  logic        cur_dual;
  logic [4:0]  wait_cnt;
  logic [1:0]  beat;
  logic [23:0] cur_addr;
  logic [63:0] cur_wdata;
  logic [63:0] rdata;
  logic        bad_req;
  logic        go;
  logic [3:0]  sel_wait;
  logic [1:0]  last_beat;

  // unmapped, refused fetch or false condition: answered with no pin activity
  assign bad_req   = ~|hit || !fetch_ok;                            // R22 R10
  assign go        = req_valid && req_ready;
  assign req_ready = (state == ST_IDLE);
  // dual-element access moves four 16-bit beats on the 64-bit path
  assign last_beat = cur_dual ? 2'h3 : 2'h1;                        // R09
  always_comb
  begin
    sel_wait = WAIT_RESET;
    for (int b = 0; b < NUM_BANKS; b++)
      if (cur_sel[b])
        sel_wait = cur_sdram ? sdram_latency : async_wait[4*b +: 4]; // R02 R07
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ST_BOOT;
      cur_sel   <= 4'h0;
      cur_sdram <= 1'b0;
      cur_write <= 1'b0;
      cur_dual  <= 1'b0;
      wait_cnt  <= 5'h00;
      beat      <= 2'h0;
      cur_addr  <= 24'h00_0000;
      cur_wdata <= 64'h0000_0000_0000_0000;
      rdata     <= 64'h0000_0000_0000_0000;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      resp_valid <= 1'b0;
      case (state)
        ST_BOOT:
          if (!boot_active)
            state <= ST_IDLE;
        ST_IDLE:
          if (go)
          begin
            if (bad_req || !req_cond_true)                          // R15 R22
            begin
              resp_valid <= 1'b1;
              resp_error <= bad_req;
              resp_rdata <= 64'h0000_0000_0000_0000;
            end
            else
            begin
              state     <= ST_ACCESS;
              cur_sel   <= hit;
              cur_sdram <= hit_sdram;                               // R23
              cur_write <= (req_kind == KIND_WRITE);
              cur_dual  <= req_dual && hit_sdram;                   // R09
              cur_addr  <= req_addr[23:0];
              cur_wdata <= req_wdata;
              beat      <= 2'h0;
              wait_cnt  <= 5'h00;
              // no stale upper half from an earlier dual access
              rdata     <= 64'h0000_0000_0000_0000;
            end
          end
        ST_ACCESS:
          // programmed wait count plus one, so the two-flop ack and data
          // copies already show the bus as it was after the strobe rose
          if (wait_cnt > {1'b0, sel_wait})                          // R13
            state <= ST_WAIT_ACK;
          else
            wait_cnt <= wait_cnt + 5'h01;
        ST_WAIT_ACK:
          // ack low holds the beat open; sdram ignores it
          if (ack_ok || cur_sdram)                                  // R13
          begin
            rdata[16*beat +: 16] <= din_sync;
            if (beat == last_beat)
              state <= ST_DONE;
            else
            begin
              beat     <= beat + 2'h1;
              cur_addr <= cur_addr + 24'h00_0001;
              wait_cnt <= 5'h00;
              state    <= ST_ACCESS;
            end
          end
        ST_DONE:
        begin
          resp_valid <= 1'b1;
          resp_error <= 1'b0;
          resp_rdata <= rdata;
          cur_sel    <= 4'h0;
          state      <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic active;
  assign active = (state == ST_ACCESS) || (state == ST_WAIT_ACK);

  // selects follow the latched address; idle reads inactive high
  assign bank_select_n        = active ? ~cur_sel[1:0] : 2'h3;            // R01 R14 R15
  assign bank_select_oe       = (state != ST_BOOT);                       // R19
  // shared pins are flag inputs until a select use is enabled
  assign shared_flag_pin_2    = !(active && cur_sel[2]);                  // R20
  assign shared_flag_pin_2_oe = sel23_enable[0] && (state != ST_BOOT);    // R20
  assign shared_flag_pin_3    = !(active && cur_sel[3]);                  // R20
  assign shared_flag_pin_3_oe = sel23_enable[1] && (state != ST_BOOT);    // R20
  assign async_read_strobe    = active && !cur_sdram && !cur_write;       // R16
  assign async_write_strobe   = active && !cur_sdram && cur_write;        // R17
  assign strobe_oe            = (state != ST_BOOT);                       // R19
  assign sdram_cycle          = active && cur_sdram;                      // R06
  // boot drives address low; reset leaves it undriven
  assign addr_out             = (state == ST_BOOT) ? 24'h00_0000 : cur_addr; // R18 R19
  assign addr_oe              = rst_n;                                    // R19
  // data pins: memory bus or low eight as flags
  assign data_out   = data_flag_mode ? {8'h00, gp_flag_out}
                                     : cur_wdata[16*beat +: 16];          // R21
  assign data_oe    = data_flag_mode ? {8'h00, gp_flag_oe}
                                     : {16{async_write_strobe
                                           || (sdram_cycle && cur_write)}};
  assign gp_flag_in = din_sync[7:0];                                      // R21

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_wait_held;
    active && !cur_sdram && !ack_ok;
  endsequence

  a_ack_holds: assert property (@(posedge clk) disable iff (!rst_n)
    s_wait_held |=> state != ST_DONE) else $error("access done while ack low"); // R13
  a_idle_no_sel: assert property (@(posedge clk) disable iff (!rst_n)
    !active |-> bank_select_n == 2'h3) else $error("select active when idle"); // R15
  a_read_strobe: assert property (@(posedge clk) disable iff (!rst_n) // R16
    (go && !bad_req && req_cond_true && req_kind == KIND_READ && !hit_sdram)
      |=> async_read_strobe) else $error("read strobe missing");
  a_write_strobe: assert property (@(posedge clk) disable iff (!rst_n) // R17
    async_write_strobe |-> cur_write && !async_read_strobe)
    else $error("write strobe wrong");
  a_unmapped_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (go && bad_req) |=> !active ##1 !active) else $error("unmapped access started"); // R22
  a_cond_false: assert property (@(posedge clk) disable iff (!rst_n)
    (go && !req_cond_true) |=> resp_valid && !active) else $error("false cond ran"); // R15
  a_fetch_bank0: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (go && req_kind == KIND_FETCH_FIXED && !hit[0]) |=> resp_error)
    else $error("fetch outside bank zero");
  a_sel_match: assert property (@(posedge clk) disable iff (!rst_n)
    active |-> $onehot(cur_sel)) else $error("select not one-hot"); // R14
  a_boot_addr_low: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_BOOT |-> addr_out == 24'h00_0000 && addr_oe) else $error("boot addr"); // R19

  // an accepted access must give the ack synchroniser time to see the strobe
  sequence s_access_taken;
    go && !bad_req && req_cond_true;
  endsequence

  a_ack_settle: assert property (@(posedge clk) disable iff (!rst_n) // R13
    s_access_taken |=> (state == ST_ACCESS) [*2]) else $error("ack window too short");
  a_done_answer: assert property (@(posedge clk) disable iff (!rst_n) // R13
    state == ST_DONE |=> resp_valid && !resp_error) else $error("no answer after access");

endmodule
`default_nettype wire

//--- sim/ext_mem_model.sv
// behavioural sixteen-bit asynchronous memory at the far side of the port
// assumes strobes already qualified by select and enable in the bench
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
(
  // clock and pins
  input  wire logic        clk,
  input  wire logic [23:0] addr,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  // wait cycles after strobe rise
  input  wire logic [3:0]  slow,
  // answer
  output logic [15:0]      rdata,
  output logic             drive,
  output logic             ack_n
);
  logic [15:0] mem [0:255]; // sixteen-bit part
  logic [3:0]  cnt;
  // store a written word
  always_ff @(posedge clk)
  begin
    if (wr)
      mem[addr[7:0]] <= wdata;
  end
  // count cycles of the current strobe
  always_ff @(posedge clk)
  begin
    if (!(rd || wr))
      cnt <= 4'h0;
    else if (cnt != 4'hF)
      cnt <= cnt + 4'h1;
  end
  // ack low only early in a strobe; idle pull-up keeps it high
  assign ack_n = !((rd || wr) && (cnt < slow));
  assign drive = rd;
  assign rdata = mem[addr[7:0]];
endmodule
`default_nettype wire

//--- sim/external_port_bank_decoder_tb.sv
// self-checking bench for the external port decoder
// assumes the memory model answers async reads; data pins pull up when idle
`timescale 1ns/1ps
`default_nettype none
module external_port_bank_decoder_tb
  import ext_port_pkg::*;
;
  logic clk, arst_n, req_valid, req_ready, req_cond_true, req_dual;
  logic resp_valid, resp_error, data_flag_mode, boot_active, addr_oe;
  logic bank_select_oe, shared_flag_pin_2, shared_flag_pin_2_oe;
  logic shared_flag_pin_3, shared_flag_pin_3_oe, async_read_strobe;
  logic async_write_strobe, strobe_oe, sdram_cycle, async_wait_ack_n, mem_drive;
  logic rd_seen, wr_seen, sd_seen, got_err;
  access_kind_t req_kind;
  logic [31:0] req_addr;
  logic [63:0] req_wdata, resp_rdata, got_data;
  logic [3:0]  bank_is_sdram, sdram_latency, slow, sel_now, sel_seen;
  logic [11:0] sdram_size;
  logic [15:0] async_wait, data_in, data_out, data_oe, mem_rdata;
  logic [1:0]  sel23_enable, bank_select_n;
  logic [23:0] addr_out;
  logic [7:0]  gp_flag_out, gp_flag_oe, gp_flag_in;
  int err_count, n_compared, lat, lat1, lat2;

  // -------------------------------------------------------------
  // pins and far side
  // -------------------------------------------------------------
  assign data_in = (data_oe & data_out) | (~data_oe & (mem_drive ? mem_rdata : 16'hFFFF));
  assign sel_now = {shared_flag_pin_3_oe & ~shared_flag_pin_3,
                    shared_flag_pin_2_oe & ~shared_flag_pin_2,
                    {2{bank_select_oe}} & ~bank_select_n};
  external_port_bank_decoder dut (.*);
  ext_mem_model mem (.clk(clk), .addr(addr_out), .slow(slow),
    .rd(async_read_strobe & strobe_oe & (sel_now != 4'h0)),
    .wr(async_write_strobe & strobe_oe & (sel_now != 4'h0)),
    .wdata(data_out), .rdata(mem_rdata), .drive(mem_drive), .ack_n(async_wait_ack_n));

  // -------------------------------------------------------------
  // clock, watchdog, compares
  // -------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // whole run is a few hundred cycles
  initial
  begin
    #(100 * 20000);
    err_count++;
    results();
  end
  task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_word(what, {63'h0, exp}, {63'h0, got});
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // -------------------------------------------------------------
  // one request, observed until its answer
  // -------------------------------------------------------------
  task automatic access(input logic [31:0] a, input access_kind_t k, input logic c);
    int i;
    @(negedge clk);
    for (i = 0; i < 50 && req_ready !== 1'b1; i++)
      @(negedge clk);
    req_addr = a;
    req_kind = k;
    req_cond_true = c;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    {sel_seen, rd_seen, wr_seen, sd_seen} = '0;
    for (lat = 1; lat < 300 && resp_valid !== 1'b1; lat++)
    begin
      sel_seen |= sel_now;
      rd_seen |= async_read_strobe & strobe_oe;
      wr_seen |= async_write_strobe & strobe_oe;
      sd_seen |= sdram_cycle;
      @(negedge clk);
    end
    got_err = resp_error;
    got_data = resp_rdata;
    check_bit("answer", 1'b1, resp_valid);
  endtask
  // decoded select, refusal and strobes of the last access
  task automatic check_pins(input logic [3:0] s, input logic e, input logic r, input logic w);
    check_word("select", {60'h0, s}, {60'h0, sel_seen});
    check_bit("error", e, got_err);
    check_bit("read strobe", r, rd_seen);
    check_bit("write strobe", w, wr_seen);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic test_windows();
    logic [31:0] a [11] = '{32'h0020_0000, 32'h007F_FFFF, 32'h0080_0000, 32'h0400_0000,
      32'h047F_FFFF, 32'h0480_0000, 32'h087F_FFFF, 32'h0C00_0000, 32'h0C7F_FFFF,
      32'h0C80_0000, 32'h001F_FFFF};
    logic [3:0] s [11] = '{4'h1, 4'h1, 4'h0, 4'h2, 4'h2, 4'h0, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0};
    for (int i = 0; i < 11; i++)
    begin
      access(a[i], KIND_READ, 1'b1);
      check_pins(s[i], s[i] == 4'h0, s[i] != 4'h0, 1'b0);
    end
  endtask
  task automatic test_write_read();
    req_wdata = 64'h0000_0000_BEEF_1234;
    access(32'h0020_0010, KIND_WRITE, 1'b1);
    check_pins(4'h1, 1'b0, 1'b0, 1'b1);
    access(32'h0020_0010, KIND_READ, 1'b1);
    check_word("read data", 64'hBEEF_1234, {32'h0, got_data[31:0]});
  endtask
  task automatic test_waits();
    async_wait = 16'h0300;
    access(32'h0400_0000, KIND_READ, 1'b1);
    lat1 = lat;
    access(32'h0800_0000, KIND_READ, 1'b1);
    lat2 = lat;
    check_word("wait diff", 64'd6, 64'(lat2 - lat1));
    slow = 4'h3;
    access(32'h0400_0000, KIND_READ, 1'b1);
    slow = 4'h0;
    check_bit("ack stretch", 1'b1, lat > lat1);
    access(32'h0020_0000, KIND_READ, 1'b0);
    check_pins(4'h0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic test_fetch();
    access(32'h005F_FFFF, KIND_FETCH_FIXED, 1'b1);
    check_pins(4'h1, 1'b0, 1'b1, 1'b0);
    access(32'h0060_0000, KIND_FETCH_FIXED, 1'b1);
    check_pins(4'h0, 1'b1, 1'b0, 1'b0);
    access(32'h0060_0000, KIND_FETCH_COMP, 1'b1);
    check_pins(4'h0, 1'b1, 1'b0, 1'b0);
    access(32'h0400_0000, KIND_FETCH_FIXED, 1'b1);
    check_pins(4'h0, 1'b1, 1'b0, 1'b0);
    bank_is_sdram = 4'h3;
    access(32'h0060_0000, KIND_FETCH_COMP, 1'b1);
    check_pins(4'h1, 1'b0, 1'b0, 1'b0);
    check_bit("sdram cycle", 1'b1, sd_seen);
  endtask
  task automatic test_sdram();
    access(32'h07FF_FFFF, KIND_READ, 1'b1);
    check_pins(4'h2, 1'b0, 1'b0, 1'b0);
    check_bit("sdram cycle", 1'b1, sd_seen);
    req_dual = 1'b1;
    access(32'h0080_0000, KIND_READ, 1'b1);
    req_dual = 1'b0;
    check_pins(4'h1, 1'b0, 1'b0, 1'b0);
    check_word("dual data", 64'hFFFF_FFFF_FFFF_FFFF, got_data);
    sdram_size = 12'h006;
    access(32'h041F_FFFF, KIND_READ, 1'b1);
    check_pins(4'h2, 1'b0, 1'b0, 1'b0);
    check_word("single data", 64'h0000_0000_FFFF_FFFF, got_data);
    access(32'h0420_0000, KIND_READ, 1'b1);
    check_pins(4'h0, 1'b1, 1'b0, 1'b0);
    access(32'h0800_0000, KIND_READ, 1'b1);
    check_bit("async strobe", 1'b1, rd_seen & ~sd_seen);
  endtask
  task automatic test_flags();
    data_flag_mode = 1'b1;
    gp_flag_oe = 8'hFF;
    gp_flag_out = 8'hA5;
    repeat (4) @(negedge clk);
    check_word("flag loop", 64'hA5, {56'h0, gp_flag_in});
    data_flag_mode = 1'b0;
    gp_flag_oe = 8'h00;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    {arst_n, req_valid, req_dual, data_flag_mode, req_cond_true} = '0;
    {req_addr, req_wdata, bank_is_sdram, async_wait, slow, gp_flag_out, gp_flag_oe} = '0;
    req_kind = KIND_READ;
    sdram_size = 12'h036;
    sdram_latency = 4'h2;
    sel23_enable = 2'b00;
    boot_active = 1'b1;
    repeat (2) @(negedge clk);
    check_word("oe in reset", 64'h0, 64'({addr_oe, bank_select_oe, strobe_oe, data_oe}));
    check_word("pins in reset", 64'h3,
      64'({async_read_strobe, async_write_strobe, bank_select_n}));
    repeat (14) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check_word("boot addr", 64'h1_000000, 64'({addr_oe, addr_out}));
    check_bit("ready in boot", 1'b0, req_ready);
    check_word("flag pins", 64'h0, 64'({shared_flag_pin_2_oe, shared_flag_pin_3_oe}));
    boot_active = 1'b0;
    sel23_enable = 2'b11;
    test_windows();
    test_write_read();
    test_waits();
    test_fetch();
    test_sdram();
    test_flags();
    results();
  end
endmodule
`default_nettype wire
